// *** verilog/two_wire_master.sv ***
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"
// two wire master sequencer with apb registers
module two_wire_master #(
  parameter int unsigned QUARTER = `TW_QUARTER_CYC
) (
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // bus clock pin
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  // bus data pin
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // flag level for software polling
  output logic             interrupt_flag
);
  typedef struct packed {
    two_wire_pkg::eng_state_t st;
    two_wire_pkg::action_t    after_stop;
    logic [7:0]  control;
    logic [4:0]  code;
    logic [1:0]  presc;
    logic [7:0]  data;
    logic [7:0]  shift;
    logic [2:0]  bitn;
    logic [1:0]  phase;
    logic        is_addr;
    logic        rx_mode;
    logic        master;
    logic        busy;
    logic        scl_lo;
    logic        sda_lo;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } core_state_t;
  core_state_t c_reg;
  core_state_t c_next;
  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;
  logic tick;
  // pin synchronisers
  two_wire_sync u_scl (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (scl_in),
    .pin_sync(scl_s)
  );
  two_wire_sync u_sda (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (sda_in),
    .pin_sync(sda_s)
  );
  // quarter bit timing
  two_wire_tick #(.QUARTER(QUARTER)) u_tick (
    .clk_sys(clk_sys),
    .rst    (rst),
    .run    (c_reg.st != two_wire_pkg::ST_IDLE && c_reg.st != two_wire_pkg::ST_HOLD),
    .tick   (tick)
  );
  // delayed copies for bus start and stop detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  // raise flag with a status code
  function automatic core_state_t post(input core_state_t s, input logic [7:0] code);
    core_state_t r;
    r = s;
    r.code = code[7:3];
    r.control[`TW_BIT_INT] = 1'b1;
    r.st = two_wire_pkg::ST_HOLD;
    return r;
  endfunction
  // decode the action from a control write
  function automatic two_wire_pkg::action_t decode(input logic sta, input logic sto,
                                                   input logic master);
    if (sta && sto) begin
      return two_wire_pkg::ACT_STOPSTART;
    end else if (sta) begin
      return two_wire_pkg::ACT_START;
    end else if (sto) begin
      return two_wire_pkg::ACT_STOP;
    end else if (master) begin
      return two_wire_pkg::ACT_BYTE;
    end else begin
      return two_wire_pkg::ACT_RELEASE;
    end
  endfunction
  logic                  wr_acc;
  logic                  rd_acc;
  logic                  ack_bit;
  two_wire_pkg::action_t act;
  // next state for registers and bus engine
  always_comb begin
    c_next = c_reg;
    wr_acc = psel && penable && pwrite && !c_reg.pready;
    rd_acc = psel && penable && !pwrite && !c_reg.pready;
    ack_bit = 1'b0;
    act = two_wire_pkg::ACT_NONE;
    c_next.pready = psel && penable && !c_reg.pready;
    c_next.pslverr = 1'b0;
    // bus busy tracking from start and stop seen on the pins
    if (scl_s && sda_q && !sda_s) begin
      c_next.busy = 1'b1;
    end else if (scl_s && !sda_q && sda_s) begin
      c_next.busy = 1'b0;
    end
    // register reads
    if (rd_acc) begin
      case (paddr)
        `TW_CONTROL_ADDR: c_next.prdata = {24'h000000, c_reg.control};
        `TW_STATUS_ADDR:  c_next.prdata = {24'h000000, c_reg.code, 1'b0, c_reg.presc};
        `TW_DATA_ADDR:    c_next.prdata = {24'h000000, c_reg.data};
        default: begin
          c_next.prdata  = 32'h00000000;
          c_next.pslverr = 1'b1;
        end
      endcase
    end
    // register writes
    if (wr_acc) begin
      case (paddr)
        `TW_CONTROL_ADDR: begin
          c_next.control[`TW_BIT_EA]  = pwdata[`TW_BIT_EA];
          c_next.control[`TW_BIT_STA] = pwdata[`TW_BIT_STA];
          c_next.control[`TW_BIT_STO] = pwdata[`TW_BIT_STO];
          c_next.control[`TW_BIT_EN]  = pwdata[`TW_BIT_EN];
          c_next.control[`TW_BIT_IE]  = pwdata[`TW_BIT_IE];
          if (pwdata[`TW_BIT_INT] && c_reg.control[`TW_BIT_INT]) begin
            c_next.control[`TW_BIT_INT] = 1'b0;
            c_next.control[`TW_BIT_WC]  = 1'b0;
            if (pwdata[`TW_BIT_EN]) begin
              act = decode(pwdata[`TW_BIT_STA], pwdata[`TW_BIT_STO], c_reg.master);
            end
          end else if (pwdata[`TW_BIT_INT] && pwdata[`TW_BIT_EN] &&
                       c_reg.st == two_wire_pkg::ST_IDLE && pwdata[`TW_BIT_STA]) begin
            act = two_wire_pkg::ACT_START;
          end
          if (!pwdata[`TW_BIT_EN]) begin
            c_next.st = two_wire_pkg::ST_IDLE;
            c_next.master = 1'b0;
            c_next.scl_lo = 1'b0;
            c_next.sda_lo = 1'b0;
          end
        end
        `TW_STATUS_ADDR: c_next.presc = pwdata[1:0];
        `TW_DATA_ADDR: begin
          if (c_reg.control[`TW_BIT_INT]) begin
            c_next.data = pwdata[7:0];
          end else begin
            c_next.control[`TW_BIT_WC] = 1'b1;
          end
        end
        default: c_next.pslverr = 1'b1;
      endcase
    end
    // launch the requested action
    case (act)
      two_wire_pkg::ACT_START: begin
        c_next.st = two_wire_pkg::ST_WFREE;
        c_next.phase = 2'd0;
      end
      two_wire_pkg::ACT_BYTE: begin
        c_next.st = two_wire_pkg::ST_BIT;
        c_next.shift = c_reg.rx_mode && !c_reg.is_addr ? 8'hff : c_reg.data;
        c_next.bitn = 3'd7;
        c_next.phase = 2'd0;
      end
      two_wire_pkg::ACT_STOP, two_wire_pkg::ACT_STOPSTART: begin
        c_next.st = two_wire_pkg::ST_STOP;
        c_next.after_stop = act;
        c_next.phase = 2'd0;
      end
      two_wire_pkg::ACT_RELEASE: begin
        c_next.st = two_wire_pkg::ST_IDLE;
        c_next.scl_lo = 1'b0;
        c_next.sda_lo = 1'b0;
        c_next.code = 5'(`TW_ST_IDLE >> 3);
      end
      default: ;
    endcase
    // bus engine on quarter bit ticks
    if (tick) begin
      c_next.phase = c_reg.phase + 2'd1;
      case (c_reg.st)
        two_wire_pkg::ST_WFREE: begin
          // wait for a free bus, release lines first
          c_next.scl_lo = 1'b0;
          c_next.sda_lo = 1'b0;
          if (c_reg.busy && !c_reg.master) begin
            c_next.phase = 2'd0;
          end else if (c_reg.phase == 2'd3 && scl_s) begin
            c_next.st = two_wire_pkg::ST_START;
            c_next.phase = 2'd0;
          end
        end
        two_wire_pkg::ST_START: begin
          if (c_reg.phase == 2'd0) begin
            c_next.sda_lo = 1'b1;
          end else if (c_reg.phase == 2'd2) begin
            c_next.scl_lo = 1'b1;
          end else if (c_reg.phase == 2'd3) begin
            c_next.is_addr = 1'b1;
            c_next = post(c_next, c_reg.master ? `TW_ST_RSTART : `TW_ST_START);
            c_next.master = 1'b1;
            c_next.control[`TW_BIT_STA] = 1'b0;
          end
        end
        two_wire_pkg::ST_BIT, two_wire_pkg::ST_ACK: begin
          if (c_reg.phase == 2'd0) begin
            if (c_reg.st == two_wire_pkg::ST_BIT) begin
              c_next.sda_lo = !c_reg.shift[7];
            end else begin
              // receiver answers with ack_enable, transmitter releases
              c_next.sda_lo = c_reg.rx_mode && !c_reg.is_addr && c_reg.control[`TW_BIT_EA];
            end
          end else if (c_reg.phase == 2'd1) begin
            c_next.scl_lo = 1'b0;
          end else if (c_reg.phase == 2'd2) begin
            if (!scl_s) begin
              c_next.phase = c_reg.phase; // slave stretching
            end else if (c_reg.st == two_wire_pkg::ST_BIT) begin
              c_next.shift = {c_reg.shift[6:0], sda_s};
              if (!c_reg.sda_lo && !sda_s && !(c_reg.rx_mode && !c_reg.is_addr)) begin
                c_next.master = 1'b0;
                c_next.scl_lo = 1'b0;
                c_next.sda_lo = 1'b0;
                c_next = post(c_next, `TW_ST_ARB);
              end
            end
          end else begin
            c_next.scl_lo = 1'b1;
            if (c_reg.st == two_wire_pkg::ST_BIT) begin
              c_next.bitn = c_reg.bitn - 3'd1;
              if (c_reg.bitn == 3'd0) begin
                c_next.st = two_wire_pkg::ST_ACK;
              end
            end else begin
              ack_bit = !sda_q;
              c_next.sda_lo = 1'b0;
              if (c_reg.is_addr) begin
                c_next.is_addr = 1'b0;
                c_next.rx_mode = c_reg.data[0];
                if (c_reg.data[0]) begin
                  c_next = post(c_next, ack_bit ? `TW_ST_AR_ACK : `TW_ST_AR_NACK);
                end else begin
                  c_next = post(c_next, ack_bit ? `TW_ST_AW_ACK : `TW_ST_AW_NACK);
                end
              end else if (c_reg.rx_mode) begin
                c_next.data = c_reg.shift;
                c_next = post(c_next, c_reg.control[`TW_BIT_EA] ? `TW_ST_DR_ACK
                                                                : `TW_ST_DR_NACK);
              end else begin
                c_next = post(c_next, ack_bit ? `TW_ST_DT_ACK : `TW_ST_DT_NACK);
              end
            end
          end
        end
        two_wire_pkg::ST_STOP: begin
          if (c_reg.phase == 2'd0) begin
            c_next.sda_lo = 1'b1;
          end else if (c_reg.phase == 2'd1) begin
            c_next.scl_lo = 1'b0;
          end else if (c_reg.phase == 2'd2) begin
            c_next.sda_lo = 1'b0;
          end else begin
            c_next.master = 1'b0;
            c_next.rx_mode = 1'b0;
            c_next.control[`TW_BIT_STO] = 1'b0;
            c_next.code = 5'(`TW_ST_IDLE >> 3);
            c_next.st = c_reg.after_stop == two_wire_pkg::ACT_STOPSTART ?
                        two_wire_pkg::ST_WFREE : two_wire_pkg::ST_IDLE;
          end
        end
        default: c_next.phase = 2'd0;
      endcase
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      c_reg <= '{st: two_wire_pkg::ST_IDLE, after_stop: two_wire_pkg::ACT_NONE,
                 control: `TW_CONTROL_RST, code: 5'h1f, presc: 2'b00,
                 data: `TW_DATA_RST, shift: 8'h00, bitn: 3'd7, phase: 2'd0,
                 is_addr: 1'b0, rx_mode: 1'b0, master: 1'b0, busy: 1'b0,
                 scl_lo: 1'b0, sda_lo: 1'b0, prdata: 32'h00000000,
                 pready: 1'b0, pslverr: 1'b0};
    end else begin
      c_reg <= c_next;
    end
  end
  // outputs straight from state flops, scl_out and sda_out tied low
  assign prdata  = c_reg.prdata;
  assign pready  = c_reg.pready;
  assign pslverr = c_reg.pslverr;
  assign scl_out = 1'b0;
  assign scl_oe  = c_reg.scl_lo;
  assign sda_out = 1'b0;
  assign sda_oe  = c_reg.sda_lo;
  assign interrupt_flag = c_reg.control[`TW_BIT_INT];
endmodule // two_wire_master
`default_nettype wire

// *** shared/two_wire_map.svh ***
// Overview of operation
// - byte sent and acknowledged: flag set, status 28.
// - byte sent, no acknowledge: flag set, status 30, same follow-ups allowed.
// - clear flag with start and stop zero: send loaded byte, sample acknowledge.
// - clear flag with start one, stop zero: send repeated start.
// - clear flag with stop only: send stop, then clear stop request.
// - clear flag with start and stop: stop then start, stop request cleared.
// - arbitration lost: status 38; clear with start and stop zero releases bus, not addressed.
// - after arbitration loss, clear with start: wait for free bus, then start.
// - start request write: test bus, generate start once free.
// - start sent: flag set, status 08.
// - after read address and acknowledge: flag set, status 38, 40 or 48.
// - received byte sits in data register once flag is set.
// - after repeated start (status 10) any slave or direction may follow.
// - data write while flag low is discarded and sets write collision.
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH
// register byte addresses
`define TW_CONTROL_ADDR 12'h000
`define TW_STATUS_ADDR  12'h004
`define TW_DATA_ADDR    12'h008
// control bit positions
`define TW_BIT_INT   7
`define TW_BIT_EA    6
`define TW_BIT_STA   5
`define TW_BIT_STO   4
`define TW_BIT_WC    3
`define TW_BIT_EN    2
`define TW_BIT_IE    0
// status codes
`define TW_ST_START    8'h08
`define TW_ST_RSTART   8'h10
`define TW_ST_AW_ACK   8'h18
`define TW_ST_AW_NACK  8'h20
`define TW_ST_DT_ACK   8'h28
`define TW_ST_DT_NACK  8'h30
`define TW_ST_ARB      8'h38
`define TW_ST_AR_ACK   8'h40
`define TW_ST_AR_NACK  8'h48
`define TW_ST_DR_ACK   8'h50
`define TW_ST_DR_NACK  8'h58
`define TW_ST_IDLE     8'hf8
// reset values
`define TW_CONTROL_RST 8'h00
`define TW_DATA_RST    8'hff
// quarter bit period in system clocks
`define TW_QUARTER_CYC 16'd25
`endif

// *** shared/two_wire_pkg.sv ***
package two_wire_pkg;
  // bus engine states, gray along start-bit-ack path
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_START = 4'b0001,
    ST_BIT   = 4'b0011,
    ST_ACK   = 4'b0010,
    ST_HOLD  = 4'b0110,
    ST_STOP  = 4'b0111,
    ST_WFREE = 4'b0101
  } eng_state_t;
  // action requested when the flag is cleared
  typedef enum logic [2:0] {
    ACT_NONE, ACT_START, ACT_BYTE, ACT_STOP, ACT_STOPSTART, ACT_RELEASE
  } action_t;
endpackage

// *** verilog/two_wire_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// two flop synchroniser for one pin input
module two_wire_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // pin and synchronised level
  input  wire logic pin_in,
  output logic      pin_sync
);
  typedef struct packed {
    logic meta;
    logic sync;
  } sync_state_t;
  sync_state_t s_reg;
  sync_state_t s_next;
  // meta flop feeds only the second flop
  always_comb begin
    s_next.meta = pin_in;
    s_next.sync = s_reg.meta;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= 2'b11;
    end else begin
      s_reg <= s_next;
    end
  end
  assign pin_sync = s_reg.sync;
endmodule // two_wire_sync
`default_nettype wire

// *** verilog/two_wire_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"
// quarter bit enable divider
module two_wire_tick #(
  parameter int unsigned QUARTER = `TW_QUARTER_CYC
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // run and enable pulse
  input  wire logic run,
  output logic      tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_state_t;
  tick_state_t t_reg;
  tick_state_t t_next;
  // refuse a divider that the 16-bit counter cannot serve
  if (QUARTER < 2 || QUARTER > 65535) begin : g_bad_quarter
    $error("QUARTER out of range");
  end
  // count down, pulse at wrap
  always_comb begin
    t_next = t_reg;
    t_next.tick = 1'b0;
    if (!run) begin
      t_next.cnt = 16'(QUARTER - 1);
    end else if (t_reg.cnt == 16'h0000) begin
      t_next.cnt  = 16'(QUARTER - 1);
      t_next.tick = 1'b1;
    end else begin
      t_next.cnt = t_reg.cnt - 16'h0001;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end
  assign tick = t_reg.tick;
endmodule // two_wire_tick
`default_nettype wire

// *** tb/two_wire_master_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"
// port checker for the two wire master
module two_wire_master_properties #(
  parameter int unsigned QUARTER = `TW_QUARTER_CYC
) (
  // system
  input wire logic        clk_sys,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and flag
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        interrupt_flag
);
  localparam int BIT_MAX = 8 * QUARTER;
  logic done;
  logic mapped;
  logic clear_w;
  // finished access; flag clearing write is taken in the first access cycle
  assign done    = psel && penable && pready;
  assign mapped  = paddr inside {`TW_CONTROL_ADDR, `TW_STATUS_ADDR, `TW_DATA_ADDR};
  assign clear_w = psel && penable && !pready && pwrite && paddr == `TW_CONTROL_ADDR &&
                   pwdata[`TW_BIT_INT];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // bus steps
  sequence s_clear_held; clear_w && interrupt_flag && scl_oe; endsequence
  sequence s_scl_free; ##[1:BIT_MAX] !scl_oe; endsequence
  sequence s_start_edge; $rose(sda_oe) && !scl_oe; endsequence
  sequence s_stop_edge; $fell(sda_oe) && !scl_oe; endsequence
  property p_pready_pulse; pready |=> !pready; endproperty
  property p_answer; psel && penable && !pready |=> pready; endproperty
  property p_slverr; done |-> pslverr == !mapped; endproperty
  property p_flag_clear; clear_w && interrupt_flag |=> !interrupt_flag; endproperty
  property p_flag_hold; interrupt_flag && !clear_w |=> interrupt_flag; endproperty
  property p_hold_bus;
    interrupt_flag && $past(interrupt_flag) && $past(interrupt_flag, 2)
      |-> $stable(scl_oe) && $stable(sda_oe);
  endproperty
  property p_flag_rise; $rose(interrupt_flag) |-> scl_oe || !sda_oe; endproperty
  property p_resume; s_clear_held |-> s_scl_free; endproperty
  property p_start; s_start_edge |-> ##[1:BIT_MAX] scl_oe; endproperty
  property p_stop; s_stop_edge |-> !interrupt_flag [*2]; endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready high for more than one cycle");
  a_answer: assert property (p_answer)
    else $error("no pready one cycle into the access");
  a_slverr: assert property (p_slverr)
    else $error("pslverr does not match the address map");
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by control write");
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without a clearing write");
  a_hold_bus: assert property (p_hold_bus)
    else $error("bus lines moved while flag high");
  a_flag_rise: assert property (p_flag_rise)
    else $error("flag set with data low and clock free");
  a_resume: assert property (p_resume)
    else $error("clock still held after flag clear");
  a_start: assert property (p_start)
    else $error("start not followed by clock low");
  a_stop: assert property (p_stop)
    else $error("flag set around stop");
endmodule // two_wire_master_properties
bind two_wire_master two_wire_master_properties #(.QUARTER(QUARTER)) u_props (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .interrupt_flag(interrupt_flag));
`default_nettype wire

// *** tb/two_wire_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural slave on the bus, never stretches the clock
module two_wire_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // sampling clock
  input  wire logic       clk_sys,
  // bus wires and behaviour controls
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack_data,
  input  wire logic [7:0] tx_byte,
  // data line pull down
  output logic            sda_oe
);
  logic       scl_q, sda_q, active, rd, addr_ph;
  logic [3:0] cnt;
  logic [7:0] sh;
  initial {scl_q, sda_q, active, rd, addr_ph, sda_oe, cnt, sh} = 18'h30000;
  // edge detection, bit counting, ack and read data
  always @(posedge clk_sys) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin // start seen
      {active, addr_ph, cnt, sda_oe} <= {2'b11, 4'h0, 1'b0};
    end else if (!active || (scl && scl_q && !sda_q && sda)) begin // idle or stop
      {active, sda_oe} <= 2'b00;
    end else if (scl && !scl_q) begin
      cnt <= (cnt == 4'd8) ? 4'd0 : cnt + 4'd1;
      if (cnt != 4'd8)
        sh <= {sh[6:0], sda};
      else if (addr_ph)
        {active, rd, addr_ph} <= {sh[7:1] == ADDR, sh[0], 1'b0};
      else if (rd && sda)
        active <= 1'b0; // master nack ends the read
    end else if (!scl && scl_q) begin
      if (cnt == 4'd8)
        sda_oe <= addr_ph ? (sh[7:1] == ADDR) : (!rd && !nack_data);
      else
        sda_oe <= rd && !addr_ph && !tx_byte[~cnt[2:0]];
    end
  end
endmodule // two_wire_slave_model
`default_nettype wire

// *** tb/two_wire_master_tx_rx_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
// bench for the two wire master sequencer
module two_wire_master_tx_rx_sequencer_tb_top;
  localparam logic [6:0] SLV = 7'h2a;
  localparam logic [7:0] C_START = 8'ha4, C_GO = 8'h84, C_ACK = 8'hc4;
  localparam logic [7:0] C_STOP = 8'h94, C_BOTH = 8'hb4;
  localparam logic [11:0] CTL = `TW_CONTROL_ADDR, STA = `TW_STATUS_ADDR, DAT = `TW_DATA_ADDR;
  logic        clk_sys = 1'b0, rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, scl_out, scl_oe, sda_out, sda_oe;
  logic        interrupt_flag, slv_oe;
  logic        nack_data = 1'b0, arb_low = 1'b0;
  logic [7:0]  tx_byte = 8'h96;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || slv_oe || arb_low);
  int          n_errors = 0, comparisons = 0;
  always #5 clk_sys = !clk_sys;
  two_wire_master #(.QUARTER(4)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .interrupt_flag(interrupt_flag));
  two_wire_slave_model #(.ADDR(SLV)) u_slv (
    .clk_sys(clk_sys), .scl(scl), .sda(sda), .nack_data(nack_data), .tx_byte(tx_byte),
    .sda_oe(slv_oe));
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // look between edges, where the registered answer has settled
    do begin
      @(negedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_errors++;
    rdat = prdata;
    rerr = pslverr;
    // the edge that samples pready high ends the access
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rdat & {24'h0, m}, {24'h0, e})
  endtask
  // wait for the flag, then read the masked status code
  task automatic wait_flag(input logic [7:0] code);
    int k;
    k = 0;
    while (interrupt_flag !== 1'b1 && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 2000) n_errors++;
    @(posedge clk_sys);
    rd_chk(STA, 8'hf8, code);
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, STA, 8'h00);
      k++;
    end while (rdat[7:3] !== 5'h1f && k < 40);
    `CHK(rdat[7:3], 5'h1f)
    `CHK(interrupt_flag, 1'b0)
    rd_chk(CTL, 8'h10, 8'h00);
  endtask
  task automatic summarize;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // reset values, unmapped access, prescaler, collision
  task automatic t_regs;
    rd_chk(CTL, 8'hff, `TW_CONTROL_RST);
    rd_chk(STA, 8'hff, 8'hf8);
    rd_chk(DAT, 8'hff, `TW_DATA_RST);
    apb(1'b1, 12'h00c, 8'h5a);
    `CHK(rerr, 1'b1)
    wr(STA, 8'h02);
    rd_chk(STA, 8'hff, 8'hfa);
    wr(DAT, 8'h55);
    rd_chk(CTL, 8'h08, 8'h08);
    rd_chk(DAT, 8'hff, 8'hff);
    $display("test regs done");
  endtask
  // address and data bytes, nack, repeated start
  task automatic t_tx;
    wr(CTL, C_START);
    wait_flag(`TW_ST_START);
    wr(DAT, {SLV, 1'b0});
    wr(CTL, C_GO);
    wait_flag(`TW_ST_AW_ACK);
    wr(DAT, 8'h3c);
    wr(CTL, C_GO);
    wait_flag(`TW_ST_DT_ACK);
    `CHK(u_slv.sh, 8'h3c)
    nack_data <= 1'b1;
    wr(DAT, 8'hc3);
    wr(CTL, C_GO);
    wait_flag(`TW_ST_DT_NACK);
    nack_data <= 1'b0;
    wr(DAT, 8'h5a);
    wr(CTL, C_GO);
    wait_flag(`TW_ST_DT_ACK);
    `CHK(u_slv.sh, 8'h5a)
    wr(CTL, C_START);
    wait_flag(`TW_ST_RSTART);
    $display("test tx done");
  endtask
  // receive two bytes, stop plus start, absent slave, stop
  task automatic t_rx;
    wr(DAT, {SLV, 1'b1});
    wr(CTL, C_GO);
    wait_flag(`TW_ST_AR_ACK);
    wr(CTL, C_ACK);
    wait_flag(`TW_ST_DR_ACK);
    rd_chk(DAT, 8'hff, 8'h96);
    tx_byte <= 8'h9b; // bit 7 left the slave one cycle after the flag, before this write
    wr(CTL, C_GO);
    wait_flag(`TW_ST_DR_NACK);
    rd_chk(DAT, 8'hff, 8'h9b);
    wr(CTL, C_BOTH);
    wait_flag(`TW_ST_START);
    rd_chk(CTL, 8'h10, 8'h00);
    wr(DAT, {~SLV, 1'b1});
    wr(CTL, C_GO);
    wait_flag(`TW_ST_AR_NACK);
    wr(CTL, C_STOP);
    wait_idle;
    $display("test rx done");
  endtask
  // lost arbitration: release, then start once the bus is free
  task automatic t_arb;
    wr(CTL, C_START);
    wait_flag(`TW_ST_START);
    arb_low <= 1'b1;
    wr(DAT, 8'ha0);
    wr(CTL, C_GO);
    wait_flag(`TW_ST_ARB);
    `CHK({scl_oe, sda_oe}, 2'b00)
    `CHK({scl_out, sda_out}, 2'b00)
    wr(CTL, C_GO);
    wait_idle;
    arb_low <= 1'b0;
    wr(CTL, C_START);
    wait_flag(`TW_ST_START);
    arb_low <= 1'b1;
    wr(DAT, 8'ha0);
    wr(CTL, C_GO);
    wait_flag(`TW_ST_ARB);
    wr(CTL, C_START);
    repeat (100) @(posedge clk_sys);
    `CHK(interrupt_flag, 1'b0)
    arb_low <= 1'b0; // other master stops
    wait_flag(`TW_ST_START);
    wr(CTL, C_STOP);
    wait_idle;
    $display("test arb done");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs;
    t_tx;
    t_rx;
    t_arb;
    summarize;
  end
  // watchdog
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
endmodule // two_wire_master_tx_rx_sequencer_tb_top
`default_nettype wire
